// >>> rtl/sac_pkg.sv
// package: register map, field layout and types of the sprite attribute bank
package sac_pkg;
  // ==========================================================
  // register indices (byte address = 4 * index within a sprite slot)
  localparam logic [2:0] IDX_CTRL = 3'h0;
  localparam logic [2:0] IDX_RSVD = 3'h2;
  localparam logic [2:0] IDX_LOW = 3'h4;
  localparam logic [2:0] IDX_HIGH = 3'h6;
  // ==========================================================
  // address layout: sprite slot of 32 bytes, 16 sprites
  localparam int ADDR_W = 12;
  localparam int SPR_LSB = 5;
  localparam int NUM_SPR = 16;
  // ==========================================================
  // general control field positions
  localparam int ROT_LSB = 10;
  localparam int MIRROR_BIT = 9;
  localparam int TRANSP_BIT = 8;
  localparam int ARB_BIT = 7;
  localparam int FMT_BIT = 1;
  localparam int EN_BIT = 0;
  // ==========================================================
  // writable bits of each word; the rest read as zero
  localparam logic [15:0] CTRL_MASK = 16'hff83;
  localparam logic [15:0] LOW_MASK = 16'hff80;
  localparam logic [15:0] HIGH_MASK = 16'h07ff;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam int ADDR_LOW_ZEROS = 7;
  // ==========================================================
  // clockwise fixed rotation
  typedef enum logic [1:0] {
    ROT_0 = 2'b00,
    ROT_90 = 2'b01,
    ROT_180 = 2'b10,
    ROT_270 = 2'b11
  } sac_rot_e;

  function automatic logic idx_known(input logic [2:0] idx);
    idx_known = (idx == IDX_CTRL) || (idx == IDX_RSVD) || (idx == IDX_LOW) || (idx == IDX_HIGH);
  endfunction
endpackage

// >>> rtl/sac_ctrl_dec.sv
// decoder: general control word into the attributes the engine uses
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl_dec import sac_pkg::*; (
  // control word
  input wire logic [15:0] ctrl,
  // decoded attributes
  output sac_rot_e rot,
  output logic quarter,
  output logic corner_bl,
  output logic mirror,
  output logic transp,
  output logic arb,
  output logic tile,
  output logic en
);
  assign rot = sac_rot_e'(ctrl[ROT_LSB +: 2]);
  assign quarter = (rot == ROT_90) || (rot == ROT_270);
  // a cropped frame starts at the top left of the rotated view
  assign corner_bl = quarter;
  assign mirror = ctrl[MIRROR_BIT];
  assign transp = ctrl[TRANSP_BIT];
  assign arb = ctrl[ARB_BIT];
  assign tile = ctrl[FMT_BIT];
  assign en = ctrl[EN_BIT];
endmodule
`default_nettype wire

// >>> rtl/sac_addr_join.sv
// joins the two start address words into a byte address
`timescale 1ns/1ps
`default_nettype none
module sac_addr_join import sac_pkg::*; (
  // stored words
  input wire logic [15:0] low,
  input wire logic [15:0] high,
  // byte address and alignment
  output logic [26:0] addr,
  output logic aligned
);
  assign addr = {high[10:0], low[15:7], {ADDR_LOW_ZEROS{1'b0}}};
  // bit 7 set breaks the 256-byte alignment
  assign aligned = ~low[7];
endmodule
`default_nettype wire

// >>> rtl/sac_top.sv
// sprite attribute register bank: apb slave plus engine read port
// How it works
// - rotation field 00/01/10/11 means 0/90/180/270 degrees clockwise
// - cropped frame shows top left; bottom left of original at 90/270
// - nonzero rotation on sprite zero also rotates the output window
// - control bit 9 set mirrors the sprite horizontally
// - control bit 8 set makes transparent pixels see-through
// - control bit 7 enables arbitrary-angle rotation
// - control bit 1 selects stream (0) or 8x8 tile (1) layout
// - control bit 0 enables the sprite; one must be on before triggering
`timescale 1ns/1ps
`default_nettype none
module sac_top import sac_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // apb slave
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // engine read port
  input wire logic eng_req,
  input wire logic [3:0] eng_sprite,
  output logic eng_valid,
  output logic eng_en,
  output logic [1:0] eng_rot,
  output logic eng_corner_bl,
  output logic eng_mirror,
  output logic eng_transp,
  output logic eng_arb,
  output logic eng_tile,
  output logic [26:0] eng_addr,
  output logic eng_addr_ok,
  output logic win_rot
);
  // ==========================================================
  // reset release
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ==========================================================
  // bus decode
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  wire [3:0] bus_spr = paddr[SPR_LSB +: 4];
  wire [2:0] bus_idx = paddr[4:2];
  wire mapped = (paddr[ADDR_W-1:9] == 3'h0) && (paddr[1:0] == 2'h0) && idx_known(bus_idx);
  wire first_acc = psel & penable & ~pready_q;
  wire done = psel & penable & pready_q;
  // the reserved word is never written, so a write there is refused
  wire wr_rsvd = pwrite & (bus_idx == IDX_RSVD);
  wire wr_en = done & pwrite & mapped & ~wr_rsvd;
  wire [15:0] wdat = pwdata[15:0];

  // ==========================================================
  // storage: one identical set per sprite
  logic [15:0] ctrl_q [NUM_SPR];
  logic [15:0] low_q [NUM_SPR];
  logic [15:0] high_q [NUM_SPR];
  // cleared at reset so no sprite starts enabled with stale attributes
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int i = 0; i < NUM_SPR; i++) begin
        ctrl_q[i] <= WORD_RESET;
        low_q[i] <= WORD_RESET;
        high_q[i] <= WORD_RESET;
      end
    end else if (wr_en) begin
      case (bus_idx)
        IDX_CTRL: ctrl_q[bus_spr] <= wdat & CTRL_MASK;
        IDX_LOW: low_q[bus_spr] <= wdat & LOW_MASK;
        IDX_HIGH: high_q[bus_spr] <= wdat & HIGH_MASK;
        default: ;
      endcase
    end
  end

  wire [15:0] rd_word = (bus_idx == IDX_CTRL) ? ctrl_q[bus_spr] :
                        (bus_idx == IDX_LOW) ? low_q[bus_spr] :
                        (bus_idx == IDX_HIGH) ? high_q[bus_spr] : WORD_RESET;

  // ==========================================================
  // apb answer: one wait state, pready raised from a flop
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= first_acc;
      if (first_acc) begin
        pslverr_q <= ~mapped | wr_rsvd;
        prdata_q <= (!pwrite && mapped) ? {16'h0, rd_word} : 32'h0;
      end else if (done) begin
        pslverr_q <= 1'b0;
      end
    end
  end
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ==========================================================
  // engine read port
  wire [15:0] sel_ctrl = ctrl_q[eng_sprite];
  wire [15:0] sel_low = low_q[eng_sprite];
  wire [15:0] sel_high = high_q[eng_sprite];
  sac_rot_e d_rot;
  logic d_quarter;
  logic d_corner;
  logic d_mirror;
  logic d_transp;
  logic d_arb;
  logic d_tile;
  logic d_en;
  logic [26:0] d_addr;
  logic d_aligned;

  sac_ctrl_dec u_dec (
    .ctrl(sel_ctrl),
    .rot(d_rot),
    .quarter(d_quarter),
    .corner_bl(d_corner),
    .mirror(d_mirror),
    .transp(d_transp),
    .arb(d_arb),
    .tile(d_tile),
    .en(d_en)
  );

  sac_addr_join u_addr (
    .low(sel_low),
    .high(sel_high),
    .addr(d_addr),
    .aligned(d_aligned)
  );

  logic valid_q;
  logic en_q;
  logic [1:0] rot_q;
  logic corner_q;
  logic mirror_q;
  logic transp_q;
  logic arb_q;
  logic tile_q;
  logic [26:0] addr_q;
  logic addr_ok_q;
  logic win_rot_q;
  // a disabled sprite presents all-zero attributes to the engine
  wire g = d_en;
  wire rot0_nz = (ctrl_q[0][ROT_LSB +: 2] != ROT_0);

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      valid_q <= 1'b0;
      en_q <= 1'b0;
      rot_q <= ROT_0;
      corner_q <= 1'b0;
      mirror_q <= 1'b0;
      transp_q <= 1'b0;
      arb_q <= 1'b0;
      tile_q <= 1'b0;
      addr_q <= 27'h0;
      addr_ok_q <= 1'b0;
      win_rot_q <= 1'b0;
    end else begin
      valid_q <= eng_req;
      win_rot_q <= rot0_nz;
      if (eng_req) begin
        en_q <= d_en;
        rot_q <= g ? d_rot : ROT_0;
        corner_q <= g & d_corner;
        mirror_q <= g & d_mirror;
        transp_q <= g & d_transp;
        arb_q <= g & d_arb;
        tile_q <= g & d_tile;
        addr_q <= g ? d_addr : 27'h0;
        addr_ok_q <= g & d_aligned;
      end
    end
  end

  assign eng_valid = valid_q;
  assign eng_en = en_q;
  assign eng_rot = rot_q;
  assign eng_corner_bl = corner_q;
  assign eng_mirror = mirror_q;
  assign eng_transp = transp_q;
  assign eng_arb = arb_q;
  assign eng_tile = tile_q;
  assign eng_addr = addr_q;
  assign eng_addr_ok = addr_ok_q;
  assign win_rot = win_rot_q;

  // ==========================================================
  // checks
  a_rot_decode: assert property (@(posedge clk) disable iff (!rst_n_q)
    eng_req |=> rot_q == ($past(sel_ctrl[EN_BIT]) ? $past(sel_ctrl[11:10]) : 2'b00))
    else $error("rotation code not passed to engine");
  a_corner_pick: assert property (@(posedge clk) disable iff (!rst_n_q)
    valid_q |-> corner_q == (rot_q == ROT_90 || rot_q == ROT_270))
    else $error("display corner does not match rotation");
  a_window_rot: assert property (@(posedge clk) disable iff (!rst_n_q)
    rot0_nz [*2] |-> win_rot_q)
    else $error("window not rotated for rotated background");
  a_mirror_bit: assert property (@(posedge clk) disable iff (!rst_n_q)
    eng_req |=> mirror_q == ($past(sel_ctrl[MIRROR_BIT]) && $past(sel_ctrl[EN_BIT])))
    else $error("mirror attribute wrong");
  a_transp_bit: assert property (@(posedge clk) disable iff (!rst_n_q)
    eng_req |=> transp_q == ($past(sel_ctrl[TRANSP_BIT]) && $past(sel_ctrl[EN_BIT])))
    else $error("transparency attribute wrong");
  a_arb_bit: assert property (@(posedge clk) disable iff (!rst_n_q)
    eng_req |=> arb_q == ($past(sel_ctrl[ARB_BIT]) && $past(sel_ctrl[EN_BIT])))
    else $error("arbitrary rotation attribute wrong");
  a_tile_bit: assert property (@(posedge clk) disable iff (!rst_n_q)
    eng_req |=> tile_q == ($past(sel_ctrl[FMT_BIT]) && $past(sel_ctrl[EN_BIT])))
    else $error("image format attribute wrong");
  a_enable_bit: assert property (@(posedge clk) disable iff (!rst_n_q)
    eng_req |=> valid_q && en_q == $past(sel_ctrl[EN_BIT]))
    else $error("enable attribute wrong");
  a_start_addr: assert property (@(posedge clk) disable iff (!rst_n_q)
    eng_req && sel_ctrl[EN_BIT] |=> addr_q[6:0] == 7'h0 &&
      addr_q[26:7] == {$past(sel_high[10:0]), $past(sel_low[15:7])})
    else $error("start address formed wrongly");
  a_disabled_zero: assert property (@(posedge clk) disable iff (!rst_n_q)
    valid_q && !en_q |-> !(mirror_q || transp_q || arb_q || tile_q) && addr_q == 27'h0 && rot_q == 2'b00)
    else $error("disabled sprite attributes exposed");
  a_apb_wait: assert property (@(posedge clk) disable iff (!rst_n_q)
    first_acc |=> pready_q ##1 !pready_q)
    else $error("apb answer timing wrong");

  // ==========================================================
  // bus, storage and hold checks
  a_pready_idle: assert property (@(posedge clk) disable iff (!rst_n_q)
    !psel |-> !pready_q)
    else $error("pready raised without a selected transfer");
  a_slverr_clear: assert property (@(posedge clk) disable iff (!rst_n_q)
    pready_q |=> !pslverr_q)
    else $error("error response held past its transfer");
  a_rsvd_refused: assert property (@(posedge clk) disable iff (!rst_n_q)
    first_acc && pwrite && bus_idx == IDX_RSVD |=> pslverr_q)
    else $error("reserved word write not refused");
  a_mapped_ok: assert property (@(posedge clk) disable iff (!rst_n_q)
    first_acc && mapped && !wr_rsvd |=> !pslverr_q)
    else $error("error response on a legal access");
  a_unmapped_err: assert property (@(posedge clk) disable iff (!rst_n_q)
    first_acc && !mapped |=> pslverr_q && prdata_q == 32'h0)
    else $error("unmapped access not refused");
  a_rdata_upper: assert property (@(posedge clk) disable iff (!rst_n_q)
    pready_q |-> prdata_q[31:16] == 16'h0)
    else $error("upper read data not zero");
  a_ctrl_fill: assert property (@(posedge clk) disable iff (!rst_n_q)
    pready_q && !pwrite && bus_idx == IDX_CTRL |-> (prdata_q[15:0] & ~CTRL_MASK) == 16'h0)
    else $error("unused control bits read nonzero");
  a_low_fill: assert property (@(posedge clk) disable iff (!rst_n_q)
    pready_q && !pwrite && bus_idx == IDX_LOW |-> (prdata_q[15:0] & ~LOW_MASK) == 16'h0)
    else $error("unused low address bits read nonzero");
  a_high_fill: assert property (@(posedge clk) disable iff (!rst_n_q)
    pready_q && !pwrite && bus_idx == IDX_HIGH |-> (prdata_q[15:0] & ~HIGH_MASK) == 16'h0)
    else $error("unused high address bits read nonzero");
  a_ctrl_read: assert property (@(posedge clk) disable iff (!rst_n_q)
    first_acc && !pwrite && mapped && bus_idx == IDX_CTRL |=> prdata_q[15:0] == $past(ctrl_q[bus_spr]))
    else $error("control word read back wrongly");
  a_valid_pulse: assert property (@(posedge clk) disable iff (!rst_n_q)
    !eng_req |=> !valid_q)
    else $error("engine valid without a request");
  a_attr_hold: assert property (@(posedge clk) disable iff (!rst_n_q)
    !eng_req |=> $stable(en_q) && $stable(rot_q) && $stable(mirror_q) && $stable(addr_q))
    else $error("engine attributes changed without a request");
  a_win_follow: assert property (@(posedge clk) disable iff (!rst_n_q)
    1'b1 |=> win_rot_q == $past(rot0_nz))
    else $error("window rotation does not follow sprite zero");
  a_win_plain: assert property (@(posedge clk) disable iff (!rst_n_q)
    (!rot0_nz) [*2] |-> !win_rot_q)
    else $error("window rotated for unrotated background");
  a_disabled_ok: assert property (@(posedge clk) disable iff (!rst_n_q)
    valid_q && !en_q |-> !addr_ok_q && !corner_q)
    else $error("disabled sprite shows alignment or corner");
  a_addr_ok_bit: assert property (@(posedge clk) disable iff (!rst_n_q)
    eng_req && sel_ctrl[EN_BIT] |=> addr_ok_q == !$past(sel_low[7]))
    else $error("alignment flag wrong");
endmodule
`default_nettype wire

// >>> sim/sac_eng_model.sv
// model: compositing engine side that fetches one sprite's attributes
`timescale 1ns/1ps
`default_nettype none
module sac_eng_model (
  // clock
  input wire logic clk,
  // request and answer
  output logic eng_req,
  output logic [3:0] eng_sprite,
  input wire logic eng_valid
);
  initial begin
    eng_req = 1'b0;
    eng_sprite = 4'h0;
  end
  // index is inverted once released so a stale index cannot pass for a held one
  task automatic fetch(input logic [3:0] n, output logic v);
    @(posedge clk);
    eng_req <= 1'b1;
    eng_sprite <= n;
    @(posedge clk);
    eng_req <= 1'b0;
    eng_sprite <= ~n;
    @(posedge clk);
    v = eng_valid;
  endtask
endmodule
`default_nettype wire

// >>> sim/test_sac_top.sv
// testbench: apb and engine port tests of the sprite attribute bank
`timescale 1ns/1ps
`default_nettype none
module test_sac_top;
  logic clk, resetn, psel, penable, pwrite, pready, pslverr, eng_req, eng_valid, eng_en;
  logic eng_corner_bl, eng_mirror, eng_transp, eng_arb, eng_tile, eng_addr_ok, win_rot, err, v;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] eng_sprite;
  logic [1:0] eng_rot;
  logic [26:0] eng_addr;
  int fail_count, compares, cyc;

  sac_top DUT (.clk, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .eng_req, .eng_sprite, .eng_valid, .eng_en, .eng_rot, .eng_corner_bl, .eng_mirror, .eng_transp,
    .eng_arb, .eng_tile, .eng_addr, .eng_addr_ok, .win_rot);
  sac_eng_model u_eng (.clk, .eng_req, .eng_sprite, .eng_valid);

  // ==========================================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // request held until pready is sampled high; no wait count assumed
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [11:0] a, input logic [15:0] exp, input logic e);
    apb(1'b0, a, 16'h0000);
    chk(nm, rd, {16'h0000, exp});
    chk(nm, {31'h0, err}, {31'h0, e});
  endtask

  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      finish_test;
    end
  end

  // ==========================================================
  // tests
  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    fail_count = 0;
    compares = 0;
    cyc = 0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    rdchk("ctrl reset", 12'h060, 16'h0000, 1'b0);
    chk("win idle", win_rot, 0);
    for (int r = 0; r < 4; r++) begin
      logic [15:0] c;
      c = {4'ha, r[1:0], r[0], r[1], r == 0, 5'h00, r == 0, 1'b1};
      apb(1'b1, 12'h060, c);
      rdchk("ctrl readback", 12'h060, c, 1'b0);
      u_eng.fetch(4'h3, v);
      chk("valid", v, 1);
      chk("attr", {eng_en, eng_rot, eng_corner_bl, eng_mirror, eng_transp, eng_arb, eng_tile},
        {1'b1, r[1:0], r[0], r[0], r[1], r == 0, r == 0});
    end
    apb(1'b1, 12'h070, 16'hffff);
    rdchk("start low", 12'h070, 16'hff80, 1'b0);
    apb(1'b1, 12'h078, 16'hffff);
    rdchk("start high", 12'h078, 16'h07ff, 1'b0);
    u_eng.fetch(4'h3, v);
    chk("addr", {eng_addr_ok, eng_addr}, {1'b0, 11'h7ff, 9'h1ff, 7'h00});
    apb(1'b1, 12'h070, 16'h1200);
    u_eng.fetch(4'h3, v);
    chk("addr aligned", {eng_addr_ok, eng_addr}, {1'b1, 11'h7ff, 9'h024, 7'h00});
    u_eng.fetch(4'h5, v);
    chk("other sprite", {eng_en, eng_addr}, 0);
    // disabled words hide every attribute, arbitrary rotation with rotation 00 and tile format included
    apb(1'b1, 12'h060, 16'h0f00);
    u_eng.fetch(4'h3, v);
    chk("disabled", {eng_en, eng_rot, eng_corner_bl, eng_mirror, eng_transp, eng_arb, eng_tile, eng_addr_ok}, 0);
    chk("disabled addr", eng_addr, 0);
    apb(1'b1, 12'h060, 16'h0382);
    u_eng.fetch(4'h3, v);
    chk("disabled arb", {eng_en, eng_rot, eng_corner_bl, eng_mirror, eng_transp, eng_arb, eng_tile, eng_addr_ok}, 0);
    chk("disabled arb addr", eng_addr, 0);
    // reserved word written on purpose to see the refusal
    apb(1'b1, 12'h068, 16'h1234);
    chk("rsvd write", {31'h0, err}, 1);
    rdchk("rsvd read", 12'h068, 16'h0000, 1'b0);
    rdchk("unmapped", 12'h00c, 16'h0000, 1'b1);
    apb(1'b1, 12'h000, 16'h0c01);
    rdchk("sprite0", 12'h000, 16'h0c01, 1'b0);
    chk("win rotated", win_rot, 1);
    apb(1'b1, 12'h000, 16'h0001);
    rdchk("sprite0", 12'h000, 16'h0001, 1'b0);
    chk("win plain", win_rot, 0);
    finish_test;
  end
endmodule
`default_nettype wire
